/* File: verilog/tei_interp.sv */
// terminal escape sequence interpreter with display memory editor
`timescale 1ns/1ps
module tei_interp import tei_pkg::*; #(
  parameter int COLS = 80,
  parameter int ROWS = 24,
  parameter int FIFO_DEPTH = 16
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic char_valid_in,
  input wire logic [7:0] char_in,
  input wire logic char_from_host_in,
  input wire logic char_is_function_modifier_key_in,
  output logic char_ready_out,
  input wire logic [$clog2(COLS)-1:0] cursor_col_in,
  input wire logic [$clog2(ROWS)-1:0] cursor_row_in,
  input wire logic protect_mode_in,
  input wire logic [$clog2(ROWS*COLS)-1:0] rd_addr_in,
  output logic [8:0] rd_data_out,
  output logic block_mode_out,
  output logic all_keys_enabled_out,
  output logic graphics_mode_out,
  output logic enter_mode_out,
  output logic write_protect_clear_out,
  output logic cursor_home_out,
  output logic busy_out,
  output logic [COLS-1:0] tab_stops_out,
  output logic host_cmd_valid_out,
  output logic [7:0] host_cmd_out,
  output logic [7:0] host_arg_out,
  output logic show_valid_out,
  output logic [7:0] show_char_out,
  output logic hour_inc_out,
  output logic time_load_out,
  output logic [1:0] time_field_out,
  output logic [7:0] time_value_out
);
  localparam int CW = $clog2(COLS);
  localparam int RW = $clog2(ROWS);
  localparam int SIZE = ROWS * COLS;
  localparam int AW = $clog2(SIZE);

  // ----------------------------------------
  // input buffering
  // ----------------------------------------
  logic q_valid;
  logic [9:0] q_data;
  logic q_ready;
  logic [7:0] ch;
  logic from_host;
  logic is_function_modifier_key;

  // stall the parser while an edit runs, so order is kept
  tei_fifo #(.WIDTH(10), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .in_valid_in(char_valid_in),
    .in_data_in({char_is_function_modifier_key_in, char_from_host_in, char_in}),
    .in_ready_out(char_ready_out),
    .out_valid_out(q_valid),
    .out_data_out(q_data),
    .out_ready_in(q_ready)
  );
  assign ch = q_data[7:0];
  assign from_host = q_data[8];
  assign is_function_modifier_key = q_data[9];

  // ----------------------------------------
  // parser
  // ----------------------------------------
  tei_state_t state;
  tei_op_t op;
  logic [7:0] arg_cmd;
  logic [1:0] arg_left;
  logic take;
  logic walk_done;
  logic [AW-1:0] pos;
  logic [AW-1:0] last;
  logic [AW-1:0] cur;

  assign q_ready = (state != TEI_EDIT);
  assign take = q_valid && q_ready;
  assign busy_out = (state == TEI_EDIT);
  assign cur = AW'(cursor_row_in * COLS) + AW'(cursor_col_in);

  // map an escape code to a display edit
  function automatic tei_op_t edit_of(input logic [7:0] c);
    case (c)
      TEI_CH_CLEAR_A, TEI_CH_CLEAR_B: edit_of = TEI_OP_CLEAR_ALL;
      TEI_CH_ERASE_LINE: edit_of = TEI_OP_ERASE_LINE;
      TEI_CH_ERASE_PAGE: edit_of = TEI_OP_ERASE_PAGE;
      TEI_CH_DEL_LINE: edit_of = TEI_OP_DEL_LINE;
      TEI_CH_INS_LINE: edit_of = TEI_OP_INS_LINE;
      TEI_CH_DEL_CHAR: edit_of = TEI_OP_DEL_CHAR;
      TEI_CH_INS_CHAR: edit_of = TEI_OP_INS_CHAR;
      default: edit_of = TEI_OP_NONE;
    endcase
  endfunction

  // host commands, accepted from host only; only TEI_CH_LOAD_CUR takes argument characters
  function automatic logic host_only(input logic [7:0] c);
    host_only = (c == TEI_CH_KBD_EN) || (c == TEI_CH_KBD_DIS) ||
                (c == TEI_CH_BYP_EN) || (c == TEI_CH_BYP_DIS) ||
                (c == TEI_CH_LOAD_CUR) || (c == TEI_CH_READ_CUR);
  endfunction

  // line deletes and line inserts are inert while protect mode is on
  function automatic logic edit_allowed(input tei_op_t o);
    edit_allowed = block_mode_out && (o != TEI_OP_NONE) &&
                   !(protect_mode_in && (o == TEI_OP_DEL_LINE || o == TEI_OP_INS_LINE));
  endfunction

  // state sequencing
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      state <= TEI_IDLE;
      op <= TEI_OP_NONE;
      arg_cmd <= 8'h00;
      arg_left <= 2'd0;
    end else begin
      case (state)
        TEI_IDLE: begin
          if (take && !is_function_modifier_key && ch == TEI_CH_ESC && !enter_mode_out) begin
            state <= TEI_ESC;
          end
        end
        TEI_ESC: begin
          if (take) begin
            if (ch == TEI_CH_ESC) begin
              state <= TEI_ESC_LIT;
            end else if (edit_allowed(edit_of(ch))) begin
              op <= edit_of(ch);
              state <= TEI_EDIT;
            end else if (ch == TEI_CH_CLOCK && block_mode_out) begin
              state <= TEI_CLOCK;
            end else if (host_only(ch) && from_host) begin
              arg_cmd <= ch;
              arg_left <= (ch == TEI_CH_LOAD_CUR) ? 2'd2 : 2'd0;
              state <= (ch == TEI_CH_LOAD_CUR) ? TEI_ARG : TEI_IDLE;
            end else begin
              state <= TEI_IDLE;
            end
          end
        end
        TEI_ARG: begin
          if (take) begin
            arg_left <= arg_left - 2'd1;
            if (arg_left == 2'd1) begin
              state <= TEI_IDLE;
            end
          end
        end
        TEI_CLOCK: begin
          if (take) begin
            if (ch == TEI_CH_CLK_WR_HR || ch == TEI_CH_CLK_WR_MIN ||
                ch == TEI_CH_CLK_WR_SEC) begin
              arg_cmd <= ch;
              state <= TEI_CLK_ARG;
            end else if (ch != TEI_CH_CLK_INC_HR) begin
              state <= TEI_IDLE; // any other code leaves clock control
            end
          end
        end
        TEI_CLK_ARG: begin
          if (take) begin
            state <= TEI_CLOCK;
          end
        end
        TEI_EDIT: begin
          if (walk_done) begin
            state <= TEI_IDLE;
            op <= TEI_OP_NONE;
          end
        end
        TEI_ESC_LIT: begin
          if (take) begin
            state <= TEI_IDLE;
          end
        end
        default: state <= TEI_IDLE;
      endcase
    end
  end

  // mode flags set by escapes and function keys
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      block_mode_out <= TEI_RST_BLOCK;
      all_keys_enabled_out <= TEI_RST_ALL_KEYS;
      graphics_mode_out <= 1'b0;
      enter_mode_out <= 1'b0;
    end else if (take && is_function_modifier_key && state == TEI_IDLE) begin
      if (ch == TEI_FK_CONV) begin
        block_mode_out <= 1'b0;
      end else if (ch == TEI_FK_BLOCK) begin
        block_mode_out <= 1'b1;
      end
    end else if (take && state == TEI_ESC) begin
      if (ch == TEI_CH_ALL_KEYS) begin
        all_keys_enabled_out <= 1'b1;
      end else if (ch == TEI_CH_SEL_KEYS) begin
        all_keys_enabled_out <= 1'b0;
      end else if (ch == TEI_CH_GFX_ON) begin
        graphics_mode_out <= 1'b1;
      end else if (ch == TEI_CH_GFX_OFF) begin
        graphics_mode_out <= 1'b0;
      end else if (ch == TEI_CH_ENTER_ON) begin
        enter_mode_out <= 1'b1;
      end
    end else if (take && state == TEI_IDLE && enter_mode_out && ch == TEI_CH_ENTER_OFF) begin
      enter_mode_out <= 1'b0; // leaving enter mode needs no escape
    end
  end

  // tab stop register
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      tab_stops_out <= '0;
    end else if (take && state == TEI_ESC) begin
      case (ch)
        TEI_CH_SET_TAB: tab_stops_out[cursor_col_in] <= 1'b1;
        TEI_CH_CLR_TAB: tab_stops_out[cursor_col_in] <= 1'b0;
        TEI_CH_CLR_TABS: tab_stops_out <= '0;
        TEI_CH_TABS8: begin
          for (int i = 0; i < COLS; i++) begin
            tab_stops_out[i] <= (i % TEI_TAB_SPACING == 0);
          end
        end
        default: tab_stops_out <= tab_stops_out;
      endcase
    end
  end

  // ----------------------------------------
  // event outputs
  // ----------------------------------------
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      host_cmd_valid_out <= 1'b0;
      host_cmd_out <= 8'h00;
      host_arg_out <= 8'h00;
      show_valid_out <= 1'b0;
      show_char_out <= 8'h00;
      hour_inc_out <= 1'b0;
      time_load_out <= 1'b0;
      time_field_out <= 2'd0;
      time_value_out <= 8'h00;
    end else begin
      host_cmd_valid_out <= 1'b0;
      show_valid_out <= 1'b0;
      hour_inc_out <= 1'b0;
      time_load_out <= 1'b0;
      if (take && state == TEI_ESC && host_only(ch) && from_host &&
          ch != TEI_CH_LOAD_CUR) begin
        host_cmd_valid_out <= 1'b1;
        host_cmd_out <= ch;
        host_arg_out <= 8'h00;
      end
      if (take && state == TEI_ARG) begin
        host_cmd_valid_out <= 1'b1; // one pulse per cursor address byte
        host_cmd_out <= arg_cmd;
        host_arg_out <= ch;
      end
      // literal display: plain text, enter mode, or doubled escape
      if (take && !is_function_modifier_key && ((state == TEI_IDLE && (enter_mode_out || ch != TEI_CH_ESC)) ||
          state == TEI_ESC_LIT)) begin
        show_valid_out <= 1'b1;
        show_char_out <= ch;
      end
      if (take && state == TEI_CLOCK && ch == TEI_CH_CLK_INC_HR) begin
        hour_inc_out <= 1'b1;
      end
      if (take && state == TEI_CLK_ARG) begin
        time_load_out <= 1'b1;
        time_field_out <= 2'(arg_cmd - TEI_CH_CLK_WR_HR);
        time_value_out <= ch - TEI_CLK_VALUE_BIAS;
      end
    end
  end

  // ----------------------------------------
  // display memory walker
  // ----------------------------------------
  // bit 8 of each cell is the protect flag
  logic [8:0] vmem [SIZE];
  logic [8:0] src;
  logic [AW-1:0] row_end;
  logic [AW-1:0] start;
  logic started;

  assign row_end = AW'(cursor_row_in * COLS + COLS - 1);
  assign src = vmem[pos];

  // range of the edit; start is loaded once, last follows the cursor inputs
  always_comb begin
    start = cur;
    last = row_end;
    case (op)
      TEI_OP_CLEAR_ALL: begin
        start = '0;
        last = AW'(SIZE - 1);
      end
      TEI_OP_ERASE_PAGE: last = AW'(SIZE - 1);
      TEI_OP_DEL_LINE: begin
        start = AW'(cursor_row_in * COLS);
        last = AW'(SIZE - 1);
      end
      TEI_OP_INS_LINE: begin
        start = AW'(SIZE - 1);
        last = AW'(cursor_row_in * COLS);
      end
      TEI_OP_INS_CHAR: begin
        start = row_end;
        last = cur;
      end
      default: begin
        start = cur;
        last = row_end;
      end
    endcase
  end

  // walker step: one cell per clock; inserts walk down toward the cursor, other edits walk up
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      pos <= '0;
      started <= 1'b0;
      walk_done <= 1'b0;
    end else if (state == TEI_EDIT && !started) begin
      pos <= start;
      started <= 1'b1;
      walk_done <= 1'b0;
    end else if (state == TEI_EDIT && !walk_done) begin
      if (pos == last) begin
        walk_done <= 1'b1;
      end else if (op == TEI_OP_INS_LINE || op == TEI_OP_INS_CHAR) begin
        pos <= pos - 1'b1;
      end else begin
        pos <= pos + 1'b1;
      end
    end else begin
      started <= 1'b0;
      walk_done <= 1'b0;
    end
  end

  // memory writes for each edit kind
  always_ff @(posedge clk_in) begin
    if (state == TEI_EDIT && started && !walk_done) begin
      if (src[8]) begin
        vmem[pos] <= src;
      end else begin
      case (op)
        TEI_OP_CLEAR_ALL, TEI_OP_ERASE_LINE, TEI_OP_ERASE_PAGE: begin
          vmem[pos] <= {1'b0, TEI_CH_SPACE};
        end
        TEI_OP_DEL_LINE: begin
          vmem[pos] <= (int'(pos) + COLS < SIZE) ? vmem[AW'(int'(pos) + COLS)]
                                                  : {1'b0, TEI_CH_SPACE};
        end
        TEI_OP_INS_LINE: begin
          vmem[pos] <= (int'(pos) >= int'(last) + COLS) ? vmem[AW'(int'(pos) - COLS)]
                                                        : {1'b0, TEI_CH_SPACE};
        end
        TEI_OP_DEL_CHAR: begin
          // a protected neighbour stops the pull; the gap fills with space
          vmem[pos] <= (pos != last && !vmem[pos + 1'b1][8]) ? vmem[pos + 1'b1]
                                                              : {1'b0, TEI_CH_SPACE};
        end
        TEI_OP_INS_CHAR: begin
          vmem[pos] <= (pos != last && !vmem[pos - 1'b1][8]) ? vmem[pos - 1'b1]
                                                              : {1'b0, TEI_CH_SPACE};
        end
        default: vmem[pos] <= src;
      endcase
      end
    end
  end

  // side effects reported when an edit completes
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      write_protect_clear_out <= 1'b0;
      cursor_home_out <= 1'b0;
      rd_data_out <= 9'h000;
    end else begin
      write_protect_clear_out <= walk_done && op != TEI_OP_CLEAR_ALL;
      cursor_home_out <= walk_done && op == TEI_OP_CLEAR_ALL;
      rd_data_out <= vmem[rd_addr_in];
    end
  end
endmodule // tei_interp

/* File: verilog/tei_pkg.sv */
// constants and types shared by the terminal escape interpreter
package tei_pkg;
  // character codes
  localparam logic [7:0] TEI_CH_ESC = 8'h1b;
  localparam logic [7:0] TEI_CH_SPACE = 8'h20;
  localparam logic [7:0] TEI_CH_ALL_KEYS = 8'h24;
  localparam logic [7:0] TEI_CH_SEL_KEYS = 8'h25;
  localparam logic [7:0] TEI_CH_KBD_EN = 8'h22;
  localparam logic [7:0] TEI_CH_KBD_DIS = 8'h23;
  localparam logic [7:0] TEI_CH_BYP_EN = 8'h41;
  localparam logic [7:0] TEI_CH_BYP_DIS = 8'h42;
  localparam logic [7:0] TEI_CH_LOAD_CUR = 8'h3d;
  localparam logic [7:0] TEI_CH_READ_CUR = 8'h3f;
  localparam logic [7:0] TEI_CH_CLEAR_A = 8'h2b;
  localparam logic [7:0] TEI_CH_CLEAR_B = 8'h3b;
  localparam logic [7:0] TEI_CH_ERASE_LINE = 8'h54;
  localparam logic [7:0] TEI_CH_ERASE_PAGE = 8'h59;
  localparam logic [7:0] TEI_CH_DEL_LINE = 8'h52;
  localparam logic [7:0] TEI_CH_INS_LINE = 8'h45;
  localparam logic [7:0] TEI_CH_DEL_CHAR = 8'h57;
  localparam logic [7:0] TEI_CH_INS_CHAR = 8'h51;
  localparam logic [7:0] TEI_CH_SET_TAB = 8'h31;
  localparam logic [7:0] TEI_CH_CLR_TAB = 8'h32;
  localparam logic [7:0] TEI_CH_TABS8 = 8'h33;
  localparam logic [7:0] TEI_CH_CLR_TABS = 8'h30;
  localparam logic [7:0] TEI_CH_GFX_ON = 8'h3c;
  localparam logic [7:0] TEI_CH_GFX_OFF = 8'h3e;
  localparam logic [7:0] TEI_CH_CLOCK = 8'h68;
  localparam logic [7:0] TEI_CH_ENTER_ON = 8'h56;
  localparam logic [7:0] TEI_CH_ENTER_OFF = 8'h76;
  localparam logic [7:0] TEI_CH_CLK_INC_HR = 8'h32;
  localparam logic [7:0] TEI_CH_CLK_WR_HR = 8'h35;
  localparam logic [7:0] TEI_CH_CLK_WR_MIN = 8'h36;
  localparam logic [7:0] TEI_CH_CLK_WR_SEC = 8'h37;
  localparam logic [7:0] TEI_CLK_VALUE_BIAS = 8'h20;
  localparam logic [7:0] TEI_CTRL_LIMIT = 8'h20;
  // keyboard special function codes: function_modifier_key with a letter
  localparam logic [7:0] TEI_FK_CONV = 8'h53;
  localparam logic [7:0] TEI_FK_BLOCK = 8'h41;
  // tab stop spacing
  localparam int TEI_TAB_SPACING = 8;
  // reset values
  localparam logic TEI_RST_BLOCK = 1'b0;
  localparam logic TEI_RST_ALL_KEYS = 1'b0;

  // parser states
  typedef enum logic [6:0] {
    TEI_IDLE = 7'b0000001,
    TEI_ESC = 7'b0000010,
    TEI_ARG = 7'b0000100,
    TEI_CLOCK = 7'b0001000,
    TEI_CLK_ARG = 7'b0010000,
    TEI_EDIT = 7'b0100000,
    TEI_ESC_LIT = 7'b1000000
  } tei_state_t;

  // display edit commands issued to the memory walker
  typedef enum logic [3:0] {
    TEI_OP_NONE = 4'h0,
    TEI_OP_CLEAR_ALL = 4'h1,
    TEI_OP_ERASE_LINE = 4'h2,
    TEI_OP_ERASE_PAGE = 4'h3,
    TEI_OP_DEL_LINE = 4'h4,
    TEI_OP_INS_LINE = 4'h5,
    TEI_OP_DEL_CHAR = 4'h6,
    TEI_OP_INS_CHAR = 4'h7
  } tei_op_t;
endpackage

/* File: verilog/tei_fifo.sv */
// character fifo ahead of the escape interpreter
`timescale 1ns/1ps
module tei_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic in_valid_in,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic in_ready_out,
  output logic out_valid_out,
  output logic [WIDTH-1:0] out_data_out,
  input wire logic out_ready_in
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  // honest flags from the occupancy count
  assign in_ready_out = (count != (AW+1)'(DEPTH));
  assign out_valid_out = (count != '0);
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;
  assign out_data_out = mem[rd_ptr];

  // storage write
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wr_ptr] <= in_data_in;
    end
  end

  // pointers and count
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // tei_fifo

/* File: test/tei_interp_checker.sv */
// assertion checker bound to the escape interpreter ports
`timescale 1ns/1ps
module tei_interp_checker import tei_pkg::*; #(
  parameter int COLS = 80,
  parameter int ROWS = 24
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic block_mode_out,
  input wire logic all_keys_enabled_out,
  input wire logic graphics_mode_out,
  input wire logic enter_mode_out,
  input wire logic write_protect_clear_out,
  input wire logic cursor_home_out,
  input wire logic busy_out,
  input wire logic [COLS-1:0] tab_stops_out,
  input wire logic show_valid_out,
  input wire logic hour_inc_out,
  input wire logic time_load_out,
  input wire logic [1:0] time_field_out
);
  // ----------------------------------------
  // helper logic and properties
  // ----------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  int busy_cnt;
  // length of the current edit; a walker that never ends shows here
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      busy_cnt <= 0;
    end else begin
      busy_cnt <= busy_out ? busy_cnt + 1 : 0;
    end
  end
  power_conv_a:
    assert property ($fell(reset_in) |-> !block_mode_out && !all_keys_enabled_out)
    else $error("mode flags set after reset");
  edit_block_a:
    assert property ($rose(busy_out) |-> block_mode_out)
    else $error("edit started outside block mode");
  wp_clear_end_a:
    assert property (write_protect_clear_out |-> $past(busy_out) && !busy_out)
    else $error("protect clear pulse not at edit end");
  home_pulse_a:
    assert property (cursor_home_out |-> $fell(busy_out) ##1 !cursor_home_out)
    else $error("home pulse misplaced");
  edit_bound_a:
    assert property (busy_cnt <= COLS * ROWS + 8)
    else $error("edit runs too long");
  edit_freeze_a:
    assert property (busy_out && $past(busy_out) |-> $stable(tab_stops_out)
      && $stable(graphics_mode_out) && $stable(enter_mode_out))
    else $error("state changed during edit");
  edit_stall_a:
    assert property ($rose(busy_out) |-> busy_out [*3])
    else $error("edit shorter than setup");
  clock_block_a:
    assert property ((hour_inc_out || time_load_out) |-> block_mode_out)
    else $error("clock command outside block mode");
  time_field_a:
    assert property (time_load_out |-> time_field_out != 2'h3 ##1 !time_load_out)
    else $error("bad time field or long pulse");
  cover property ($rose(busy_out));
  cover property (time_load_out);
  cover property (show_valid_out);
  cover property (hour_inc_out);
endmodule // tei_interp_checker

bind tei_interp tei_interp_checker #(.COLS(COLS), .ROWS(ROWS)) chk_u (.*);

/* File: test/tei_host_model.sv */
// character source standing for the host and keyboard
`timescale 1ns/1ps
module tei_host_model (
  input wire logic clk_in,
  input wire logic ready_in,
  output logic valid_out,
  output logic [7:0] char_out,
  output logic host_out,
  output logic function_modifier_key_out
);
  // ----------------------------------------
  // offer and release
  // ----------------------------------------
  int gap = 0;
  // idle lines at time zero
  initial begin
    valid_out = 1'b0;
    char_out = 8'h00;
    host_out = 1'b1;
    function_modifier_key_out = 1'b0;
  end
  // released char and function key lines show inverted data so stale values never pass; the host line keeps its value
  task automatic idle();
    valid_out = 1'b0;
    char_out = ~char_out;
    function_modifier_key_out = ~function_modifier_key_out;
  endtask
  // called at a falling edge; holds until the edge that accepts it
  task automatic send(input logic [7:0] ch, input logic from_host, input logic fn);
    int n;
    if (gap > 0) begin
      idle();
      repeat (gap) @(negedge clk_in);
    end
    valid_out = 1'b1;
    char_out = ch;
    host_out = from_host;
    function_modifier_key_out = fn;
    n = 0;
    while (ready_in !== 1'b1 && n < 200) begin
      @(negedge clk_in);
      n++;
    end
    @(negedge clk_in);
  endtask
endmodule // tei_host_model

/* File: test/terminal_escape_interpreter_tb_top.sv */
// self-checking bench for the escape interpreter
`timescale 1ns/1ps
module terminal_escape_interpreter_tb_top import tei_pkg::*;;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  localparam int COLS = 16;
  localparam int ROWS = 2;
  typedef struct {int kind; logic [7:0] ch; int sel; logic exp;} tei_row_t;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic char_valid_in, char_from_host_in, char_is_function_modifier_key_in, char_ready_out;
  logic protect_mode_in = 1'b0;
  logic [7:0] char_in, host_cmd_out, host_arg_out, show_char_out, time_value_out;
  logic [3:0] cursor_col_in = 4'h0;
  logic cursor_row_in = 1'b0;
  logic [4:0] rd_addr_in = 5'h00;
  logic [8:0] rd_data_out;
  logic block_mode_out, all_keys_enabled_out, graphics_mode_out, enter_mode_out;
  logic write_protect_clear_out, cursor_home_out, busy_out, host_cmd_valid_out;
  logic show_valid_out, hour_inc_out, time_load_out, busy_q;
  logic [1:0] time_field_out, last_fld;
  logic [COLS-1:0] tab_stops_out;
  logic [7:0] last_val, last_cmd;
  logic [3:0] flags;
  int n_errors = 0;
  int checked = 0;
  int cnt[8];
  int base[8];
  logic [7:0] edits[8] = '{TEI_CH_CLEAR_A, TEI_CH_CLEAR_B, TEI_CH_ERASE_LINE,
    TEI_CH_ERASE_PAGE, TEI_CH_DEL_LINE, TEI_CH_INS_LINE, TEI_CH_DEL_CHAR, TEI_CH_INS_CHAR};
  tei_row_t rows[8] = '{'{2, TEI_FK_BLOCK, 0, 1'b1}, '{2, TEI_FK_CONV, 0, 1'b0},
    '{1, TEI_CH_ALL_KEYS, 1, 1'b1}, '{1, TEI_CH_SEL_KEYS, 1, 1'b0},
    '{1, TEI_CH_GFX_ON, 2, 1'b1}, '{1, TEI_CH_GFX_OFF, 2, 1'b0},
    '{1, TEI_CH_ENTER_ON, 3, 1'b1}, '{0, TEI_CH_ENTER_OFF, 3, 1'b0}};

  tei_host_model host_u (.clk_in(clk_in), .ready_in(char_ready_out), .valid_out(char_valid_in),
    .char_out(char_in), .host_out(char_from_host_in), .function_modifier_key_out(char_is_function_modifier_key_in));
  tei_interp #(.COLS(COLS), .ROWS(ROWS)) dut_u (.*);

  // ----------------------------------------
  // clock, pulse counters, helpers
  // ----------------------------------------
  // 10 MHz clock
  initial begin
    forever #50 clk_in = ~clk_in;
  end
  // pulses are one cycle wide; count them mid-cycle where they are settled
  always @(negedge clk_in) begin
    if (reset_in === 1'b0) begin
      cnt[0] += int'(busy_out === 1'b1 && busy_q === 1'b0);
      cnt[1] += int'(write_protect_clear_out === 1'b1);
      cnt[2] += int'(cursor_home_out === 1'b1);
      cnt[3] += int'(hour_inc_out === 1'b1);
      cnt[4] += int'(time_load_out === 1'b1);
      cnt[5] += int'(host_cmd_valid_out === 1'b1);
      cnt[6] += int'(show_valid_out === 1'b1);
      cnt[7] += int'(char_ready_out === 1'b0);
      if (time_load_out === 1'b1) begin
        last_val = time_value_out;
        last_fld = time_field_out;
      end
      if (host_cmd_valid_out === 1'b1) last_cmd = host_cmd_out;
    end
    busy_q = busy_out;
  end
  task automatic chk_int(input string what, input int exp, input int got);
    checked++;
    if (exp != got) begin
      n_errors++;
      $display("[FAIL] %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  task automatic chk_val(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (exp !== got) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic esc(input logic [7:0] ch, input logic from_host = 1'b1);
    host_u.send(TEI_CH_ESC, from_host, 1'b0);
    host_u.send(ch, from_host, 1'b0);
  endtask
  // wait until busy_out has stayed low for 20 cycles, long enough to drain the fifo
  task automatic settle();
    int n;
    int k;
    host_u.idle();
    n = 0;
    k = 0;
    while (k < 20 && n < 1000) begin
      @(negedge clk_in);
      n++;
      k = (busy_out === 1'b0) ? k + 1 : 0;
    end
  endtask
  task automatic snap();
    base = cnt;
  endtask
  function automatic int d(input int i);
    return cnt[i] - base[i];
  endfunction
  task automatic do_reset();
    reset_in = 1'b1;
    repeat (8) @(posedge clk_in);
    @(negedge clk_in);
    reset_in = 1'b0;
    @(negedge clk_in);
  endtask
  task automatic stop_test();
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // hang guard
  initial begin
    repeat (20000) @(posedge clk_in);
    n_errors++;
    stop_test();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    do_reset();
    foreach (rows[i]) begin
      if (rows[i].kind == 2) host_u.send(rows[i].ch, 1'b0, 1'b1);
      else if (rows[i].kind == 1) esc(rows[i].ch);
      else host_u.send(rows[i].ch, 1'b1, 1'b0);
      settle();
      flags = {enter_mode_out, graphics_mode_out, all_keys_enabled_out, block_mode_out};
      chk_val("mode flag", 8'(rows[i].exp), 8'(flags[rows[i].sel]));
    end
    host_u.send(TEI_FK_BLOCK, 1'b0, 1'b1);
    settle();
    do_reset();
    chk_val("flags after reset", 8'h01, 8'({block_mode_out, graphics_mode_out,
      all_keys_enabled_out, char_ready_out}));
    snap();
    esc(TEI_CH_ERASE_LINE);
    settle();
    chk_int("edit outside block", 0, d(0));
    host_u.send(TEI_FK_BLOCK, 1'b0, 1'b1);
    cursor_col_in = 4'h3;
    esc(TEI_CH_SET_TAB);
    settle();
    chk_val("tab set", 8'h01, 8'(tab_stops_out[3]));
    esc(TEI_CH_CLR_TAB);
    settle();
    chk_val("tab clear", 8'h00, 8'(tab_stops_out[3]));
    esc(TEI_CH_TABS8);
    settle();
    chk_int("tabs of eight", COLS / TEI_TAB_SPACING, $countones(tab_stops_out));
    esc(TEI_CH_CLR_TABS);
    settle();
    chk_val("tabs cleared", 8'h00, 8'(tab_stops_out !== '0));
    snap();
    esc(TEI_CH_CLOCK);
    host_u.send(TEI_CH_CLK_INC_HR, 1'b1, 1'b0);
    settle();
    chk_int("hour steps", 1, d(3));
    for (int f = 0; f < 3; f++) begin
      host_u.send(TEI_CH_CLK_WR_HR + 8'(f), 1'b1, 1'b0);
      host_u.send(8'h2b + 8'(f), 1'b1, 1'b0);
      settle();
      chk_val("time field", 8'(f), 8'(last_fld));
      chk_val("time value", 8'h0b + 8'(f), last_val);
    end
    host_u.send(8'h78, 1'b1, 1'b0);
    snap();
    foreach (edits[i]) esc(edits[i]);
    settle();
    chk_int("edit starts", 8, d(0));
    chk_int("protect clears", 6, d(1));
    chk_int("home pulses", 2, d(2));
    for (int a = 0; a < 32; a += 31) begin
      rd_addr_in = 5'(a);
      @(negedge clk_in);
      @(negedge clk_in);
      chk_val("cell char", TEI_CH_SPACE, rd_data_out[7:0]);
    end
    protect_mode_in = 1'b1;
    snap();
    esc(TEI_CH_DEL_LINE);
    esc(TEI_CH_INS_LINE);
    settle();
    chk_int("line edit in protect", 0, d(0));
    protect_mode_in = 1'b0;
    snap();
    esc(TEI_CH_KBD_EN, 1'b0);
    settle();
    chk_int("keyboard host cmd", 0, d(5));
    esc(TEI_CH_KBD_EN);
    settle();
    chk_int("host cmd", 1, d(5));
    chk_val("host cmd code", TEI_CH_KBD_EN, last_cmd);
    snap();
    esc(TEI_CH_ERASE_PAGE);
    repeat (9) begin
      esc(TEI_CH_GFX_OFF);
      esc(TEI_CH_GFX_ON);
    end
    settle();
    chk_val("fifo refused", 8'h01, 8'(d(7) > 0));
    chk_val("order kept", 8'h03, 8'({graphics_mode_out, char_ready_out}));
    snap();
    host_u.send(TEI_CH_ESC, 1'b1, 1'b0);
    esc(TEI_CH_ERASE_LINE);
    settle();
    chk_int("escaped edit", 0, d(0));
    chk_val("shown chars", 8'h01, 8'(d(6) > 0));
    host_u.gap = 3;
    snap();
    esc(8'h4b);
    esc(TEI_CH_GFX_OFF);
    settle();
    host_u.gap = 0;
    chk_int("unassigned escape", 0, d(0) + d(6));
    chk_val("parser idle again", 8'h00, 8'(graphics_mode_out));
    stop_test();
  end
endmodule // terminal_escape_interpreter_tb_top
